// File: dv/mcrd_proc_model.sv
// Purpose: Processor side model driving address lines 8..14 and valid strobe
// Assumes: Processor sets up a new address at the start of phi1
// Notes:   Address lines toggle and strobe stays low while held in reset, so a stale value never matches
`timescale 1ns/1ps
module mcrd_proc_model
(
   input  wire logic       clk_i,
   input  wire logic       phi1_i,
   input  wire logic       proc_reset_n_i,
   input  wire logic [6:0] want_addr_i,
   input  wire logic       want_strobe_i,
   output logic      [6:0] addr_o,
   output logic            strobe_o
);
   logic phi1_q = 1'b0;

   initial
   begin
      addr_o = 7'h00;
      strobe_o = 1'b0;
   end

   always @(posedge clk_i)
   begin
      phi1_q <= phi1_i;
      if (!proc_reset_n_i)
      begin
         addr_o   <= #1 ~addr_o;
         strobe_o <= #1 1'b0;
      end
      else if (phi1_i && !phi1_q)
      begin
         addr_o   <= #1 want_addr_i;
         strobe_o <= #1 want_strobe_i;
      end
   end
endmodule

// File: dv/mpu_clock_reset_decode_tb_top.sv
// Purpose: Self-checking bench for phase clock, reset stretcher and decode
// Assumes: Hold count shortened to 20 cycles
// Notes:   Outputs sampled on falling clock edges, away from updates
`timescale 1ns/1ps
module mpu_clock_reset_decode_tb_top;
   import mcrd_pkg::*;
   localparam int HOLD = 20;
   typedef struct {
      logic [6:0] a;
      logic       s;
      logic       ram;
      logic [5:0] pa;
      logic [3:0] pg;
      logic [2:0] pr;
      logic       top;
   } mcrd_row_s;
   mcrd_row_s rows [10] = '{
      '{7'h00, 1, 1, 6'h00, 4'h1, 3'h0, 1}, '{7'h01, 1, 1, 6'h00, 4'h1, 3'h0, 1},
      '{7'h02, 1, 0, 6'h01, 4'h1, 3'h0, 1}, '{7'h07, 1, 0, 6'h20, 4'h2, 3'h0, 1},
      '{7'h08, 1, 0, 6'h00, 4'h4, 3'h0, 1}, '{7'h5C, 1, 0, 6'h00, 4'h8, 3'h1, 0},
      '{7'h63, 1, 0, 6'h00, 4'h1, 3'h2, 0}, '{7'h74, 1, 0, 6'h00, 4'h2, 3'h4, 0},
      '{7'h12, 1, 0, 6'h00, 4'h1, 3'h0, 0}, '{7'h01, 0, 0, 6'h00, 4'h0, 3'h0, 0}};

   logic       clk_i = 1'b0;
   logic       reset_i, power_fail_n_i, want_strobe, vas;
   logic [6:0] want_addr, addr;
   logic       phi1_o, phi2_o, dbg, prst_n, halt_n, tri_ctl, top0, ram;
   logic [5:0] pa;
   logic [3:0] pg;
   logic [2:0] pr;
   int         fails = 0, checked = 0, tick = 0, cyc = 0, n;
   logic       p1q = 1'b0, seen = 1'b0;

   always #20 clk_i = ~clk_i;

   mcrd_top #(.RESET_HOLD_CYCLES(HOLD)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
      .power_fail_n_i(power_fail_n_i), .addr_hi_i(addr), .valid_address_strobe_i(vas),
      .phi1_o(phi1_o), .phi2_o(phi2_o), .data_bus_gate_o(dbg), .proc_reset_n_o(prst_n),
      .halt_n_o(halt_n), .tristate_control_in_o(tri_ctl), .top_digit_zero_decode_o(top0),
      .ram_enable_o(ram), .peripheral_adapter_enable_o(pa), .prom_group_select_o(pg),
      .prom_enable_o(pr));

   mcrd_proc_model i_proc (.clk_i(clk_i), .phi1_i(phi1_o), .proc_reset_n_i(prst_n),
      .want_addr_i(want_addr), .want_strobe_i(want_strobe), .addr_o(addr), .strobe_o(vas));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Phase clock watch, every cycle out of reset
   // ----------------------------------------------------------------
   always @(negedge clk_i)
   begin
      if (!reset_i)
      begin
         chk({phi1_o & phi2_o, dbg ^ phi2_o, halt_n, tri_ctl}, 16'h0002);
         if (phi1_o && !p1q)
         begin
            if (seen)
               chk(16'(cyc), 16'h0019);
            seen = 1'b1;
            cyc = 0;
         end
         if (!phi1_o && p1q)
            chk(16'(cyc), 16'h000B);
         cyc++;
         p1q = phi1_o;
      end
   end

   // Hang guard, well above the expected run of about 340 cycles
   always @(posedge clk_i)
   begin
      tick++;
      if (tick == 3000)
      begin
         fails++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      reset_i = 1'b1;
      power_fail_n_i = 1'b1;
      want_addr = 7'h00;
      want_strobe = 1'b0;
      repeat (12) @(negedge clk_i);
      chk({phi1_o, phi2_o, prst_n, halt_n, ram}, 16'h0002);
      @(posedge clk_i);
      #1 reset_i = 1'b0;
      repeat (HOLD + 8) @(negedge clk_i);
      chk(prst_n, 16'h0001);
      foreach (rows[i])
      begin
         @(negedge phi2_o);
         #1 want_addr = rows[i].a;
         want_strobe = rows[i].s;
         @(posedge phi1_o);
         repeat (4) @(negedge clk_i);
         chk({ram, pa, pr}, 16'h0000);
         @(posedge phi2_o);
         repeat (4) @(negedge clk_i);
         chk({ram, pa, pg, pr, top0}, {rows[i].ram, rows[i].pa, rows[i].pg, rows[i].pr,
            rows[i].top});
      end
      // Power-on pulse arriving mid-run restarts the stretch
      @(posedge clk_i);
      #1 power_fail_n_i = 1'b0;
      repeat (5) @(negedge clk_i);
      chk({prst_n, ram}, 16'h0000);
      @(posedge clk_i);
      #1 power_fail_n_i = 1'b1;
      n = 0;
      while (prst_n !== 1'b1 && n < 60)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(16'(n >= HOLD && n <= HOLD + 5), 16'h0001);
      print_verdict();
   end
endmodule

// File: rtl/mcrd_pkg.sv
// Purpose: Shared constants for the processor clock, reset and decode block
// Assumes: System clock of 25 MHz
// Notes:   Address digits are taken from address lines 8 to 14 only
package mcrd_pkg;

   // ----------------------------------------------------------------
   // Clock generation
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned OSC_HZ        = 4_000_000;
   localparam int unsigned OSC_DIV       = 4;
   // System cycles in one processor cycle (25 at 25 MHz)
   localparam int unsigned PHASE_CYCLES  = CLK_HZ / OSC_HZ * OSC_DIV + (CLK_HZ % OSC_HZ) * OSC_DIV / OSC_HZ;
   localparam int unsigned PH_CNT_W      = 5;
   typedef logic [PH_CNT_W-1:0] mcrd_phase_t;
   localparam mcrd_phase_t PHASE_LAST    = mcrd_phase_t'(PHASE_CYCLES - 1);
   localparam mcrd_phase_t PHI1_START    = 5'h01;
   localparam mcrd_phase_t PHI1_STOP     = 5'h0C;
   localparam mcrd_phase_t PHI2_START    = 5'h0D;
   localparam mcrd_phase_t PHI2_STOP     = 5'h18;

   // ----------------------------------------------------------------
   // Reset stretcher
   // ----------------------------------------------------------------
   localparam int unsigned RESET_HOLD_MS = 200;
   localparam int unsigned RESET_HOLD_CYCLES_DEF = CLK_HZ / 1000 * RESET_HOLD_MS;
   localparam int unsigned HOLD_W        = 23;
   typedef logic [HOLD_W-1:0] mcrd_hold_t;

   // ----------------------------------------------------------------
   // Address digits
   // ----------------------------------------------------------------
   localparam logic [2:0] TOP_ZERO       = 3'h0;
   localparam logic [2:0] TOP_PROM_FIRST = 3'h5;
   localparam int unsigned PROM_REGIONS  = 3;
   localparam logic [3:0] RAM_DIGIT_LO   = 4'h0;
   localparam logic [3:0] RAM_DIGIT_HI   = 4'h1;
   localparam logic [3:0] PA_DIGIT_LO    = 4'h2;
   localparam int unsigned PA_COUNT      = 6;
   localparam int unsigned PROM_GROUPS   = 4;
   localparam int unsigned GROUP_SIZE    = 4;

endpackage

// File: rtl/mcrd_sync2.sv
// Purpose: Two-flop synchroniser for a level from outside the clock domain
// Assumes: Input changes slowly compared with the clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module mcrd_sync2
#(
   parameter logic RESET_VAL = 1'b1
)
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic stage1;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         stage1 <= RESET_VAL;
         sync_o <= RESET_VAL;
      end
      else
      begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// File: rtl/mcrd_top.sv
// Purpose: Processor two-phase clock, power-on reset stretcher, address decode
// Assumes: Processor core runs from phi1/phi2 and presents address and strobe
// Notes:   All outputs registered; enables lag the address by one cycle
`timescale 1ns/1ps
module mcrd_top
   import mcrd_pkg::*;
#(
   parameter int unsigned RESET_HOLD_CYCLES = mcrd_pkg::RESET_HOLD_CYCLES_DEF
)
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        power_fail_n_i,
   input  wire logic [14:8] addr_hi_i,
   input  wire logic        valid_address_strobe_i,
   output logic             phi1_o,
   output logic             phi2_o,
   output logic             data_bus_gate_o,
   output logic             proc_reset_n_o,
   output logic             halt_n_o,
   output logic             tristate_control_in_o,
   output logic             top_digit_zero_decode_o,
   output logic             ram_enable_o,
   output logic [5:0]       peripheral_adapter_enable_o,
   output logic [3:0]       prom_group_select_o,
   output logic [2:0]       prom_enable_o
);
   import mcrd_pkg::*;

   // ----------------------------------------------------------------
   // Phase generator
   // ----------------------------------------------------------------
   mcrd_phase_t phase_cnt;
   mcrd_phase_t next_phase_cnt;
   logic        next_phi1;
   logic        next_phi2;

   always_comb
   begin
      next_phase_cnt = (phase_cnt == PHASE_LAST) ? '0 : phase_cnt + 5'h01;
      // Gaps between windows keep the phases apart
      next_phi1 = (next_phase_cnt >= PHI1_START) && (next_phase_cnt < PHI1_STOP);
      next_phi2 = (next_phase_cnt >= PHI2_START) && (next_phase_cnt < PHI2_STOP);
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         phase_cnt       <= '0;
         phi1_o          <= 1'b0;
         phi2_o          <= 1'b0;
         data_bus_gate_o <= 1'b0;
      end
      else
      begin
         phase_cnt       <= next_phase_cnt;
         phi1_o          <= next_phi1;
         phi2_o          <= next_phi2;
         data_bus_gate_o <= next_phi2;
      end
   end

   // ----------------------------------------------------------------
   // Power-on reset stretcher
   // ----------------------------------------------------------------
   logic       power_fail_n;
   mcrd_hold_t hold_cnt;
   mcrd_hold_t next_hold_cnt;

   mcrd_sync2 #(.RESET_VAL(1'b0)) u_pf_sync
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i (power_fail_n_i),
      .sync_o  (power_fail_n)
   );

   always_comb
   begin
      if (!power_fail_n)
         next_hold_cnt = mcrd_hold_t'(RESET_HOLD_CYCLES);
      else if (hold_cnt != '0)
         next_hold_cnt = hold_cnt - 23'h000001;
      else
         next_hold_cnt = hold_cnt;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         hold_cnt       <= '0;
         proc_reset_n_o <= 1'b0;
      end
      else
      begin
         hold_cnt       <= next_hold_cnt;
         // Release only once the full hold has run out
         proc_reset_n_o <= power_fail_n && (next_hold_cnt == '0);
      end
   end

   // Unused processor controls kept inactive
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         halt_n_o              <= 1'b1;
         tristate_control_in_o <= 1'b0;
      end
      else
      begin
         halt_n_o              <= 1'b1;
         tristate_control_in_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [15:0] digit_line;
   logic [7:0]  top_line;
   logic [3:0]  next_group;
   logic        next_ram;
   logic [5:0]  next_pa;
   logic [2:0]  next_prom;
   logic        gate;

   always_comb
   begin
      digit_line = '0;
      top_line   = '0;
      if (valid_address_strobe_i)
      begin
         digit_line[addr_hi_i[11:8]] = 1'b1;
         top_line[addr_hi_i[14:12]]  = 1'b1;
      end
      gate = next_phi2 && valid_address_strobe_i;
      for (int g = 0; g < PROM_GROUPS; g++)
         next_group[g] = |digit_line[g*GROUP_SIZE +: GROUP_SIZE];
      next_ram = gate && top_line[TOP_ZERO]
               && (digit_line[RAM_DIGIT_LO] || digit_line[RAM_DIGIT_HI]);
      for (int p = 0; p < PA_COUNT; p++)
         next_pa[p] = gate && top_line[TOP_ZERO] && digit_line[PA_DIGIT_LO + p];
      for (int r = 0; r < PROM_REGIONS; r++)
         next_prom[r] = gate && (|next_group) && top_line[TOP_PROM_FIRST + r];
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         top_digit_zero_decode_o     <= 1'b0;
         ram_enable_o                <= 1'b0;
         peripheral_adapter_enable_o <= '0;
         prom_group_select_o         <= '0;
         prom_enable_o               <= '0;
      end
      else
      begin
         top_digit_zero_decode_o     <= top_line[TOP_ZERO];
         ram_enable_o                <= next_ram;
         peripheral_adapter_enable_o <= next_pa;
         prom_group_select_o         <= next_group;
         prom_enable_o               <= next_prom;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [HOLD_W-1:0] low_run;

   always_ff @(posedge clk_i)
   begin
      if (reset_i || proc_reset_n_o)
         low_run <= '0;
      else if (low_run != '1)
         low_run <= low_run + 23'h000001;
   end

   a_phase_no_overlap: assert property (@(posedge clk_i) disable iff (reset_i)
      !(phi1_o && phi2_o)) else $error("phi1 and phi2 overlap");
   a_phase_period: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(phi1_o) |-> ##25 $rose(phi1_o)) else $error("processor clock period wrong");
   a_phase_order: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(phi1_o) |-> !phi2_o ##1 phi2_o [*8]) else $error("phi2 does not follow phi1");
   a_gate_phi2: assert property (@(posedge clk_i) disable iff (reset_i)
      data_bus_gate_o == phi2_o) else $error("data bus gate not on phi2");
   a_enable_timing: assert property (@(posedge clk_i) disable iff (reset_i)
      (ram_enable_o || (|peripheral_adapter_enable_o) || (|prom_enable_o)) |-> phi2_o)
      else $error("enable outside phi2");
   a_ram_decode: assert property (@(posedge clk_i) disable iff (reset_i)
      ram_enable_o |-> $past(valid_address_strobe_i && addr_hi_i[14:12] == 3'h0 && addr_hi_i[11:9] == 3'h0))
      else $error("RAM enable without RAM address");
   a_adapter_decode: assert property (@(posedge clk_i) disable iff (reset_i)
      peripheral_adapter_enable_o[0] |-> $past(valid_address_strobe_i && addr_hi_i == 7'h02))
      else $error("adapter enable on wrong address");
   a_onehot_lines: assert property (@(posedge clk_i) disable iff (reset_i)
      $onehot0({ram_enable_o, peripheral_adapter_enable_o}) && $onehot0(prom_group_select_o))
      else $error("decode lines not one-hot");
   a_prom_decode: assert property (@(posedge clk_i) disable iff (reset_i)
      prom_enable_o[0] |-> $past(addr_hi_i[14:12] == 3'h5) && prom_group_select_o != 4'h0)
      else $error("PROM enable on wrong region");
   a_strobe_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      (|prom_group_select_o || top_digit_zero_decode_o) |-> $past(valid_address_strobe_i))
      else $error("decode active without strobe");
   a_reset_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(proc_reset_n_o) |-> $past(low_run) >= RESET_HOLD_CYCLES)
      else $error("processor reset released early");
   a_unused_inactive: assert property (@(posedge clk_i) disable iff (reset_i)
      halt_n_o && !tristate_control_in_o) else $error("halt or three-state active");

   c_ram_access: cover property (@(posedge clk_i) disable iff (reset_i) ram_enable_o);
   c_adapter_access: cover property (@(posedge clk_i) disable iff (reset_i) |peripheral_adapter_enable_o);
   c_prom_access: cover property (@(posedge clk_i) disable iff (reset_i) |prom_enable_o);
   c_reset_release: cover property (@(posedge clk_i) disable iff (reset_i) $rose(proc_reset_n_o));
endmodule
